// ---- core/polling_bitcheck_sequencer.sv ----
// Purpose: self-polling sleep, start-up and bit-check sequencer with AHB-Lite registers
// Assumes: hclk is the crystal oscillator clock, zero-wait-state slave
// Notes: demodulator and override pins are synchronised before use
`timescale 1ns/1ps
// Summary of operation
// [RULE1] basic clock is crystal divided 28 or 30
// [RULE2] extended period 8, 4, 2, 1 basic periods
// [RULE3] loop sleep, start-up, bit-check while polling
// [RULE4] processing off in sleep, on from start-up
// [RULE5] activity indicator high outside sleep
// [RULE6] ignore demodulator edges before bit-check
// [RULE7] sleep lasts sleep times factor times 1024
// [RULE8] extension factor 8 when bit set
// [RULE9] maximum sleep value means permanent sleep
// [RULE10] 0, 3, 6, 9 bits need 0-18 intervals
// [RULE11] all checks pass: receive, route data out
// [RULE12] counter clocked per extended period, compared at edges
// [RULE13] edge below lower limit aborts to sleep
// [RULE14] counter reaching upper limit aborts immediately
// [RULE15] limits are 5-bit fields in extended periods
// [RULE16] host keeps lower limit 10 or more
// [RULE17] low lower limit: host picks 6 or 9 bits
// [RULE18] host sets window about plus minus 30 percent
// [RULE19] transmitter preburst covers whole polling cycle
// [RULE20] receive mode held until commanded back
// [RULE21] override low forces start-up, keeps settings
// [RULE22] interval counter restarts at edges and entry
// [RULE23] start-up lasts a fixed number of periods
module polling_bitcheck_sequencer
  import polling_pkg::*;
#(
  parameter int SLEEP_UNIT = SLEEP_UNIT_DEFAULT
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic demod_in,
  input wire logic polling_override_n,
  output logic activity_indicator,
  output logic signal_enable,
  output logic receiving,
  output logic data_out
);
  tick_if tk ();

  logic [10:0] operating_config_register;
  logic [4:0] lim_min_reg;
  logic [4:0] lim_max_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic poll_cmd;
  logic [1:0] sync_q;
  logic demod_s;
  logic override_n_s;
  logic demod_prev_reg;
  logic edge_seen;
  poll_state_t state_reg;
  poll_state_t state_next;
  logic [17:0] sleep_cnt_reg;
  logic [17:0] sleep_target;
  logic [3:0] startup_cnt_reg;
  logic [4:0] interval_counter_value;
  logic [4:0] edges_reg;
  logic [4:0] edges_needed;
  logic [1:0] nbit;
  logic [4:0] sleep_field;
  logic [3:0] xsleep;
  logic addr_ok;
  logic [31:0] rd_value;
  logic enter_bitcheck;

  clock_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .tk(tk)
  );

  input_sync #(.WIDTH(2), .INIT(2'h3)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({polling_override_n, demod_in}),
    .q(sync_q)
  );

  assign demod_s = sync_q[0];
  assign override_n_s = sync_q[1];

  assign tk.baud_range_select = operating_config_register[CFG_BR_LSB +: 2];
  assign tk.div_sel = operating_config_register[CFG_DIVSEL_BIT];
  assign nbit = operating_config_register[CFG_NBIT_LSB +: 2];
  assign sleep_field = operating_config_register[CFG_SLEEP_LSB +: 5];
  assign xsleep = operating_config_register[CFG_XSLEEP_BIT] ? XSLEEP_LONG : XSLEEP_STD; // [RULE8]

  // ahb-lite slave, no wait states
  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb
  begin
    unique case (haddr[7:0])
      ADDR_CONFIG: rd_value = {21'h000000, operating_config_register};
      ADDR_LIMIT: rd_value = {19'h00000, lim_max_reg, 3'h0, lim_min_reg};
      ADDR_STATUS: rd_value = {27'h0000000, edges_reg == 5'h00, receiving, activity_indicator, state_reg};
      default: rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_ok && !hwrite)
      hrdata <= rd_value;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      operating_config_register <= CONFIG_RESET;
      lim_min_reg <= LIM_MIN_RESET;
      lim_max_reg <= LIM_MAX_RESET;
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == ADDR_CONFIG)
        operating_config_register <= hwdata[10:0];
      if (wr_addr_reg == ADDR_LIMIT)
      begin
        lim_min_reg <= hwdata[LIM_MIN_LSB +: 5]; // [RULE15]
        lim_max_reg <= hwdata[LIM_MAX_LSB +: 5]; // [RULE15]
      end
    end
  end

  assign poll_cmd = wr_pend_reg && (wr_addr_reg == ADDR_CONTROL) && hwdata[CTRL_POLL_BIT];

  // edge detect on synchronised demodulator output
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      demod_prev_reg <= 1'b1;
    else
      demod_prev_reg <= demod_s;
  end

  assign edge_seen = (demod_s != demod_prev_reg) && (state_reg == ST_BITCHECK); // [RULE6]

  // required interval count: 0, 6, 12, 18
  always_comb
  begin
    if (!override_n_s)
      edges_needed = 5'h00; // [RULE21]
    else
      edges_needed = 5'(nbit * 6); // [RULE10]
  end

  assign sleep_target = 18'(sleep_field * xsleep * SLEEP_UNIT); // [RULE7]
  assign enter_bitcheck = (state_reg == ST_STARTUP) && tk.basic_tick && (startup_cnt_reg == STARTUP_PERIODS - 4'h1);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SLEEP:
      begin
        if (!override_n_s)
          state_next = ST_STARTUP; // [RULE21]
        else if (sleep_field != SLEEP_PERMANENT && sleep_cnt_reg >= sleep_target) // [RULE9]
          state_next = ST_STARTUP; // [RULE3]
      end
      ST_STARTUP:
      begin
        if (enter_bitcheck)
          state_next = ST_BITCHECK; // [RULE23]
      end
      ST_BITCHECK:
      begin
        if (edges_reg >= edges_needed)
          state_next = ST_RECEIVE; // [RULE11]
        else if (edge_seen && interval_counter_value < lim_min_reg)
          state_next = ST_SLEEP; // [RULE13]
        else if (interval_counter_value >= lim_max_reg)
          state_next = ST_SLEEP; // [RULE14]
        else if (edge_seen && edges_reg + 5'h01 >= edges_needed)
          state_next = ST_RECEIVE; // [RULE11]
      end
      ST_RECEIVE:
      begin
        if (poll_cmd)
          state_next = ST_SLEEP; // [RULE20]
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= ST_SLEEP;
    else
      state_reg <= state_next;
  end

  // sleep timer in basic periods
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sleep_cnt_reg <= 18'h00000;
    else if (state_reg != ST_SLEEP)
      sleep_cnt_reg <= 18'h00000;
    else if (tk.basic_tick && sleep_cnt_reg < sleep_target)
      sleep_cnt_reg <= sleep_cnt_reg + 18'h00001; // [RULE7]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      startup_cnt_reg <= 4'h0;
    else if (state_reg != ST_STARTUP)
      startup_cnt_reg <= 4'h0;
    else if (tk.basic_tick)
      startup_cnt_reg <= startup_cnt_reg + 4'h1; // [RULE23]
  end

  // interval counter and passed-interval count
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      interval_counter_value <= 5'h00;
      edges_reg <= 5'h00;
    end
    else if (state_reg != ST_BITCHECK)
    begin
      interval_counter_value <= 5'h00; // [RULE22]
      edges_reg <= 5'h00;
    end
    else if (edge_seen)
    begin
      interval_counter_value <= 5'h00; // [RULE22]
      edges_reg <= edges_reg + 5'h01; // [RULE12]
    end
    else if (tk.xclk_tick && interval_counter_value != 5'h1F)
      interval_counter_value <= interval_counter_value + 5'h01; // [RULE12]
  end

  assign activity_indicator = (state_reg != ST_SLEEP); // [RULE5]
  assign signal_enable = (state_reg != ST_SLEEP); // [RULE4]
  assign receiving = (state_reg == ST_RECEIVE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      data_out <= 1'b1;
    else if (state_reg == ST_RECEIVE)
      data_out <= demod_s; // [RULE11]
    else
      data_out <= 1'b1;
  end
endmodule

// ---- core/polling_pkg.sv ----
// Purpose: shared constants and types of the polling and bit-check sequencer
// Assumes: hclk is the crystal oscillator clock
// Notes: register offsets are byte addresses on AHB-Lite
package polling_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [4:0] DIV_A = 5'h1C;
  localparam logic [4:0] DIV_B = 5'h1E;
  localparam logic [3:0] STARTUP_PERIODS = 4'h8;
  localparam int SLEEP_UNIT_DEFAULT = 1024;
  localparam logic [4:0] SLEEP_PERMANENT = 5'h1F;
  localparam logic [3:0] XSLEEP_LONG = 4'h8;
  localparam logic [3:0] XSLEEP_STD = 4'h1;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // config register fields
  localparam int CFG_BR_LSB = 0;
  localparam int CFG_NBIT_LSB = 2;
  localparam int CFG_SLEEP_LSB = 4;
  localparam int CFG_XSLEEP_BIT = 9;
  localparam int CFG_DIVSEL_BIT = 10;
  localparam logic [10:0] CONFIG_RESET = 11'h1F0;
  // limit register fields
  localparam int LIM_MIN_LSB = 0;
  localparam int LIM_MAX_LSB = 8;
  localparam logic [4:0] LIM_MIN_RESET = 5'h0E;
  localparam logic [4:0] LIM_MAX_RESET = 5'h18;
  localparam int CTRL_POLL_BIT = 0;
  typedef enum logic [1:0] {ST_SLEEP, ST_STARTUP, ST_BITCHECK, ST_RECEIVE} poll_state_t;
endpackage

// ---- core/tick_if.sv ----
// Purpose: carries divider settings and timing enables between modules
// Assumes: one clock domain
// Notes: ticks are one-cycle enables
`timescale 1ns/1ps
interface tick_if;
  logic div_sel;
  logic [1:0] baud_range_select;
  logic basic_tick;
  logic xclk_tick;
  modport divider (input div_sel, input baud_range_select, output basic_tick, output xclk_tick);
  modport core (output div_sel, output baud_range_select, input basic_tick, input xclk_tick);
endinterface

// ---- core/clock_divider.sv ----
// Purpose: basic and extended clock enables from the crystal clock
// Assumes: hclk is the crystal oscillator
// Notes: extended period is 8, 4, 2 or 1 basic periods
`timescale 1ns/1ps
module clock_divider
  import polling_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  tick_if.divider tk
);
  logic [4:0] div_reg;
  logic [2:0] x_reg;
  logic [2:0] x_mask;

  always_comb
  begin
    unique case (tk.baud_range_select)
      2'h0: x_mask = 3'h7;
      2'h1: x_mask = 3'h3;
      2'h2: x_mask = 3'h1;
      2'h3: x_mask = 3'h0;
    endcase
  end

  // divide by 28 or 30
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= 5'h00;
    else if (div_reg >= (tk.div_sel ? DIV_B : DIV_A) - 5'h01)
      div_reg <= 5'h00;
    else
      div_reg <= div_reg + 5'h01;
  end

  assign tk.basic_tick = (div_reg == 5'h00); // [RULE1]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      x_reg <= 3'h0;
    else if (tk.basic_tick)
      x_reg <= x_reg + 3'h1;
  end

  assign tk.xclk_tick = tk.basic_tick && ((x_reg & x_mask) == 3'h0); // [RULE2]
endmodule

// ---- core/input_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to hclk
// Notes: reset value is a parameter
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ---- test/polling_asserts.sv ----
// Purpose: port-level checks of the polling sequencer
// Assumes: one hclk domain, zero-wait bus
// Notes: bound to the top module below
`timescale 1ns/1ps
module polling_asserts
  import polling_pkg::*;
#(
  parameter int SLEEP_UNIT = SLEEP_UNIT_DEFAULT
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic demod_in,
  input wire logic polling_override_n,
  input wire logic activity_indicator,
  input wire logic signal_enable,
  input wire logic receiving,
  input wire logic data_out
);
  logic ctl_dp_reg;
  logic ctl_hit;
  logic [19:0] act_cnt_reg;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ctl_dp_reg <= 1'b0;
    else if (hready)
      ctl_dp_reg <= hsel && htrans[1] && hwrite && haddr[7:0] == ADDR_CONTROL;
  assign ctl_hit = ctl_dp_reg && hwdata[CTRL_POLL_BIT];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      act_cnt_reg <= 20'h0;
    else
      act_cnt_reg <= activity_indicator ? act_cnt_reg + 20'h1 : 20'h0;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  enable_match_a: assert property (signal_enable == activity_indicator)
    else $error("signal enable differs from activity");
  recv_active_a: assert property (receiving |-> activity_indicator)
    else $error("receiving while inactive");
  recv_entry_a: assert property ($rose(receiving) |-> $past(activity_indicator))
    else $error("receive entered straight from sleep");
  data_idle_a: assert property (!receiving && !$past(receiving) |-> data_out)
    else $error("data output not high outside receive");
  data_route_a: assert property (receiving && $past(receiving) && $past(receiving, 2)
    |-> data_out == $past(demod_in, 3)) else $error("data output not following demodulator");
  recv_hold_a: assert property ($fell(receiving) |-> $past(ctl_hit) || $past(ctl_hit, 2))
    else $error("receive left without command");
  startup_len_a: assert property ($fell(activity_indicator) |-> act_cnt_reg >= 20'hC4)
    else $error("active span shorter than start-up");
  override_wake_a: assert property (!polling_override_n [*6] |-> activity_indicator)
    else $error("override low did not wake");
endmodule
bind polling_bitcheck_sequencer polling_asserts #(.SLEEP_UNIT(SLEEP_UNIT)) i_polling_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .demod_in(demod_in), .polling_override_n(polling_override_n),
  .activity_indicator(activity_indicator), .signal_enable(signal_enable), .receiving(receiving),
  .data_out(data_out));

// ---- test/demod_source.sv ----
// Purpose: demodulator output model, fixed-frequency preburst
// Assumes: half period in hclk cycles, zero holds the line still
// Notes: changes only on the rising edge
`timescale 1ns/1ps
module demod_source
(
  input wire logic hclk,
  input wire logic [15:0] half,
  output logic demod_in
);
  logic [15:0] cnt_reg;
  initial
  begin
    demod_in = 1'b0;
    cnt_reg = 16'h0;
  end
  always @(posedge hclk)
    if (half == 16'h0)
      cnt_reg <= 16'h0;
    else if (cnt_reg + 16'h1 >= half)
    begin
      cnt_reg <= 16'h0;
      demod_in <= ~demod_in;
    end
    else
      cnt_reg <= cnt_reg + 16'h1;
endmodule

// ---- test/tb_top.sv ----
// Purpose: self-checking bench of the polling sequencer
// Assumes: 40 MHz hclk, short sleep unit
// Notes: partner toggles the demodulator line
`timescale 1ns/1ps
module tb_top
  import polling_pkg::*;
;
  localparam int SU = 4;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, demod_in, polling_override_n;
  logic activity_indicator, signal_enable, receiving, data_out, xs, dv;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [15:0] half;
  int n_mismatch, checks_done, n, hi, lo, br, bp, xc, elo, ehi;
  polling_bitcheck_sequencer #(.SLEEP_UNIT(SU)) i_polling_bitcheck_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .demod_in(demod_in), .polling_override_n(polling_override_n),
    .activity_indicator(activity_indicator), .signal_enable(signal_enable), .receiving(receiving),
    .data_out(data_out));
  demod_source i_demod_source (.hclk(hclk), .half(half), .demod_in(demod_in));
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] near(input int v, input int e, input int tol);
    return {31'h0, v >= e - tol && v <= e + tol};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic wait_sig(input logic rx, input logic v, input int max, output int c);
    c = 0;
    while ((rx ? receiving : activity_indicator) !== v && c < max)
    begin
      @(posedge hclk);
      c++;
    end
  endtask
  task automatic measure(output int l, output int h);
    wait_sig(1'b0, 1'b1, 30000, n);
    wait_sig(1'b0, 1'b0, 30000, n);
    wait_sig(1'b0, 1'b1, 30000, l);
    wait_sig(1'b0, 1'b0, 30000, h);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (95000) @(posedge hclk);
    n_mismatch++;
    print_verdict;
  end
  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    polling_override_n = 1'b1;
    half = 16'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_CONFIG, {21'h0, CONFIG_RESET}, 32'hFFFFFFFF);
    rd(ADDR_LIMIT, {19'h0, LIM_MAX_RESET, 3'h0, LIM_MIN_RESET}, 32'hFFFFFFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_STATUS, 32'h0, 32'hF);
    wait_sig(1'b0, 1'b1, 3000, n);
    chk({31'h0, activity_indicator}, 32'h0);
    polling_override_n <= 1'b0;
    wait_sig(1'b1, 1'b1, 3000, n);
    chk({31'h0, receiving}, 32'h1);
    polling_override_n <= 1'b1;
    repeat (1000) @(posedge hclk);
    chk({31'h0, receiving}, 32'h1);
    rd(ADDR_CONFIG, {21'h0, CONFIG_RESET}, 32'hFFFFFFFF);
    wr(ADDR_CONTROL, 32'h1);
    repeat (4) @(posedge hclk);
    chk({31'h0, receiving}, 32'h0);
    wait_sig(1'b0, 1'b1, 3000, n);
    chk({31'h0, activity_indicator}, 32'h0);
    wr(ADDR_LIMIT, 32'h1F0A);
    wr(ADDR_CONFIG, 32'h1B);
    half <= 16'h2BC;
    wait_sig(1'b1, 1'b1, 30000, n);
    chk({31'h0, receiving}, 32'h1);
    chk({31'h0, n >= 7700}, 32'h1);
    rd(ADDR_STATUS, 32'hF, 32'hF);
    wr(ADDR_CONTROL, 32'h1);
    wr(ADDR_CONFIG, 32'h1F);
    wait_sig(1'b1, 1'b1, 30000, n);
    chk({31'h0, receiving}, 32'h1);
    chk({31'h0, n >= 11900}, 32'h1);
    wr(ADDR_CONTROL, 32'h1);
    half <= 16'h8C;
    measure(lo, hi);
    chk(near(hi, 300, 100), 32'h1);
    chk({31'h0, receiving}, 32'h0);
    half <= 16'h0;
    for (int i = 0; i < 6; i++)
    begin
      br = (i < 4) ? i : 3;
      xs = i >= 4;
      dv = i == 5;
      bp = dv ? 30 : 28;
      xc = 8 >> br;
      wr(ADDR_CONFIG, {21'h0, dv, xs, 5'h01, 2'h2, br[1:0]});
      measure(lo, hi);
      elo = (xs ? 8 : 1) * SU * bp;
      ehi = 8 * bp + 31 * xc * bp;
      chk(near(lo, elo, 40), 32'h1);
      chk(near(hi, ehi, (xc + 2) * bp + 10), 32'h1);
    end
    print_verdict;
  end
endmodule
